// file: common/iso_input_pkg.sv
package iso_input_pkg;
  // ------------------------------------------------------------
  // register offsets within the four-byte window
  // ------------------------------------------------------------
  localparam logic [1:0] OFS_BYTE0 = 2'h0;  // inputs 0-7, clears flag 0
  localparam logic [1:0] OFS_BYTE1 = 2'h1;  // inputs 8-15
  localparam logic [1:0] OFS_BYTE2 = 2'h2;  // inputs 16-23, clears flag 16
  localparam logic [1:0] OFS_BYTE3 = 2'h3;  // inputs 24-31

  // ------------------------------------------------------------
  // decode, channel and request-line constants
  // ------------------------------------------------------------
  localparam logic [7:0] BASE_SEL_DEFAULT = 8'hC0;   // 300h >> 2
  localparam int         FIRST_CH         = 0;       // first irq source
  localparam int         SECOND_CH        = 16;      // second irq source
  localparam int         NUM_CH           = 32;      // input channels
  localparam int         NUM_LINES        = 8;       // request lines
  localparam int         BYTE_W           = 8;       // channels per byte
  localparam int         ADDR_HI          = 9;       // top decoded line
  localparam int         ADDR_LO          = 2;       // lowest decoded line
  localparam int         ARM_DEPTH        = 3;       // edges before detect
  localparam logic [7:0] NO_LINE          = 8'h00;   // irq disabled
  localparam logic       EDGE_RISE        = 1'b1;    // trigger on rise
  localparam logic       EDGE_FALL        = 1'b0;    // trigger on fall
  // request line numbers, select bit index 0..7
  localparam logic [3:0] LINE_NUM [NUM_LINES] =
    '{4'h2, 4'h3, 4'h5, 4'h7, 4'hA, 4'hB, 4'hC, 4'hF};
endpackage

// file: logic/isolated_input_port_irq.sv
`timescale 1ns/1ps
// Contract
// - four byte addresses return inputs 0-31
// - reads give present input state, bit per channel
// - any write to byte 0/2 clears flag
// - only channels 0 and 16 raise interrupts
// - defaults: channel 0 rising, channel 16 falling
// - each irq routed to one line, none disables
// - address lines 9..2 compared to base switch
module isolated_input_port_irq
  import iso_input_pkg::*;
(
  // clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 nrst_i,
  // host i/o bus
  input  wire logic [9:0]           io_addr_i,
  input  wire logic                 io_rd_i,
  input  wire logic                 io_wr_i,
  input  wire logic [7:0]           io_wdata_i,
  output logic      [7:0]           io_rdata_o,
  output logic                      io_rvalid_o,
  // board straps
  input  wire logic [7:0]           base_address_switch_i,
  input  wire logic [NUM_LINES-1:0] first_irq_line_sel_i,
  input  wire logic [NUM_LINES-1:0] second_irq_line_sel_i,
  input  wire logic                 first_edge_select_i,
  input  wire logic                 second_edge_select_i,
  // field inputs and request lines
  input  wire logic [NUM_CH-1:0]    isolated_input_i,
  output logic      [NUM_LINES-1:0] irq_line_o
);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [NUM_CH-1:0] in_meta_ff;   // first stage, read only by next
  logic [NUM_CH-1:0] in_sync_ff;   // safe copy of the field inputs
  logic [NUM_CH-1:0] in_prev_ff;   // last cycle, for edge detection

  // two flops per channel since inputs are asynchronous
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_meta_ff <= '0;
      in_sync_ff <= '0;
      in_prev_ff <= '0;
    end else begin
      in_meta_ff <= isolated_input_i;
      in_sync_ff <= in_meta_ff;
      in_prev_ff <= in_sync_ff;
    end
  end

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  // hit when address bits 9..2 match the base switch
  function automatic logic addr_hit(input logic [9:0] a,
                                    input logic [7:0] sw);
    addr_hit = (a[ADDR_HI:ADDR_LO] == sw);
  endfunction

  logic       hit;       // access inside the window
  logic [1:0] ofs;       // byte offset in window
  assign hit = addr_hit(io_addr_i, base_address_switch_i);
  assign ofs = io_addr_i[ADDR_LO-1:0];

  logic clr_first;   // write to byte 0
  logic clr_second;  // write to byte 2
  // writes to bytes 1 and 3 decode to nothing
  assign clr_first  = hit && io_wr_i && (ofs == OFS_BYTE0);
  assign clr_second = hit && io_wr_i && (ofs == OFS_BYTE2);

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // registered read data; live state at the read cycle
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_rdata_o  <= 8'h00;
      io_rvalid_o <= 1'b0;
    end else begin
      io_rvalid_o <= hit && io_rd_i;
      if (hit && io_rd_i) begin
        io_rdata_o <= in_sync_ff[BYTE_W*ofs +: BYTE_W];
      end else begin
        io_rdata_o <= 8'h00;  // idle bus reads as zero
      end
    end
  end

  // ------------------------------------------------------------
  // edge detect and interrupt flags
  // ------------------------------------------------------------
  // prev only holds a real pin sample once three edges have passed;
  // until then a pin high at release would look like a rise
  logic [ARM_DEPTH-1:0] arm_ff;   // fills with ones after release
  logic                 edge_ok;  // edge detector may fire

  // arming shift register, cleared by every reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      arm_ff <= '0;
    end else begin
      arm_ff <= {arm_ff[ARM_DEPTH-2:0], 1'b1};
    end
  end

  assign edge_ok = arm_ff[ARM_DEPTH-1];

  // chosen-edge detect, shared by both interrupt sources
  // edge select: high picks rising, low picks falling
  function automatic logic edge_seen(input logic now_lvl,
                                     input logic old_lvl,
                                     input logic rise);
    edge_seen = (rise == EDGE_RISE) ? (now_lvl & ~old_lvl) :
                                      (~now_lvl & old_lvl);
  endfunction

  logic first_evt;    // chosen edge on channel 0
  logic second_evt;   // chosen edge on channel 16
  assign first_evt  = edge_ok &&
    edge_seen(in_sync_ff[FIRST_CH], in_prev_ff[FIRST_CH],
              first_edge_select_i);
  assign second_evt = edge_ok &&
    edge_seen(in_sync_ff[SECOND_CH], in_prev_ff[SECOND_CH],
              second_edge_select_i);

  logic first_flag_ff;   // latched channel 0 request
  logic second_flag_ff;  // latched channel 16 request

  // set wins over clear so a coincident edge is not lost
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_flag_ff <= 1'b0;
    end else if (first_evt) begin
      first_flag_ff <= 1'b1;
    end else if (clr_first) begin
      first_flag_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      second_flag_ff <= 1'b0;
    end else if (second_evt) begin
      second_flag_ff <= 1'b1;
    end else if (clr_second) begin
      second_flag_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // request line routing
  // ------------------------------------------------------------
  // a flag held high keeps its line high; one-hot select assumed,
  // several jumpers fitted would drive several lines
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
      always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          irq_line_o[gi] <= 1'b0;
        end else begin
          irq_line_o[gi] <=
            (first_flag_ff  & first_irq_line_sel_i[gi]) |
            (second_flag_ff & second_irq_line_sel_i[gi]);
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_read_data: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    hit && io_rd_i |=> io_rvalid_o &&
      io_rdata_o == $past(in_sync_ff[BYTE_W*ofs +: BYTE_W]))
    else $error("read data does not match inputs");
  a_read_idle: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    !(hit && io_rd_i) |=> !io_rvalid_o)
    else $error("read valid without read");
  a_clear_first: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    clr_first && !first_evt |=> !first_flag_ff)
    else $error("flag 0 not cleared");
  a_clear_second: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    clr_second && !second_evt |=> !second_flag_ff)
    else $error("flag 16 not cleared");
  a_set_first: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    first_evt |=> first_flag_ff)
    else $error("flag 0 not set on edge");
  a_set_second: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    second_evt |=> second_flag_ff)
    else $error("flag 16 not set on edge");
  a_route_line: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    first_flag_ff && (first_irq_line_sel_i != NO_LINE) ##1
      $stable(first_irq_line_sel_i) |->
      (irq_line_o & first_irq_line_sel_i) == first_irq_line_sel_i)
    else $error("flag 0 not routed");
  a_route_second: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    second_flag_ff && (second_irq_line_sel_i != NO_LINE) ##1
      $stable(second_irq_line_sel_i) |->
      (irq_line_o & second_irq_line_sel_i) == second_irq_line_sel_i)
    else $error("flag 16 not routed");
  a_no_line: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    (first_irq_line_sel_i == NO_LINE) && (second_irq_line_sel_i == NO_LINE)
      |=> irq_line_o == NO_LINE)
    else $error("line driven with no select");
  a_flag_holds: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    second_flag_ff && !clr_second |=> second_flag_ff)
    else $error("flag 16 dropped without clear");
  a_hold_first: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    first_flag_ff && !clr_first |=> first_flag_ff)
    else $error("flag 0 dropped without clear");
  a_decode_base: assert property (
    @(posedge sys_clk_i) disable iff (!nrst_i)
    io_wr_i && (io_addr_i[9:2] != base_address_switch_i) && !first_evt
      && first_flag_ff |=> first_flag_ff)
    else $error("write outside window cleared flag");

  // main scenarios: live read, both edges, both clears
  c_read_hit:   cover property (@(posedge sys_clk_i) hit && io_rd_i);
  c_first_irq:  cover property (@(posedge sys_clk_i) first_evt);
  c_second_irq: cover property (@(posedge sys_clk_i) second_evt);
  c_clear_hit:  cover property (@(posedge sys_clk_i)
    clr_first && first_flag_ff);
  c_clear_two:  cover property (@(posedge sys_clk_i)
    clr_second && second_flag_ff);

endmodule // isolated_input_port_irq

// file: verification/host_bus_model.sv
`timescale 1ns/1ps
// host cpu: one-cycle strobes, released lines show inverted data
module host_bus_model (
  // clock
  input  wire logic       sys_clk_i,
  // i/o bus toward the card
  output logic      [9:0] io_addr_o,
  output logic            io_rd_o,
  output logic            io_wr_o,
  output logic      [7:0] io_wdata_o,
  input  wire logic [7:0] io_rdata_i,
  input  wire logic       io_rvalid_i
);
  initial begin
    io_addr_o = 10'h000;
    io_rd_o = 1'b0;
    io_wr_o = 1'b0;
    io_wdata_o = 8'h00;
  end
  // read: answer taken at the edge after the strobe
  task automatic rd(input logic [9:0] a, output logic v,
                    output logic [7:0] d);
    @(posedge sys_clk_i) #1 io_addr_o = a;
    io_rd_o = 1'b1;
    @(posedge sys_clk_i) #1 io_rd_o = 1'b0;
    io_addr_o = ~a;
    v = io_rvalid_i;
    d = io_rdata_i;
  endtask
  // write of any byte; clearing a flag is the host's job
  task automatic wr(input logic [9:0] a);
    @(posedge sys_clk_i) #1 io_addr_o = a;
    io_wr_o = 1'b1;
    io_wdata_o = 8'($urandom());
    @(posedge sys_clk_i) #1 io_wr_o = 1'b0;
    io_addr_o = ~a;
    io_wdata_o = ~io_wdata_o;
  endtask
endmodule // host_bus_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import iso_input_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic sys_clk_i = 1'b0, nrst_i = 1'b0, v, fe, se;
  logic [9:0] io_addr_i;
  logic io_rd_i, io_wr_i;
  logic [7:0] io_wdata_i, io_rdata_o, d, base, fsel, ssel, irq_line_o;
  logic io_rvalid_o;
  logic [31:0] inputs;
  int num_errors = 0, checked = 0, i, k, n;
  int mdl_in;         // model of the field pin levels
  int mdl_flag [2];   // model latches for channels 0 and 16
  int exp_q [$];      // expected read answers, oldest first
  always #5 sys_clk_i = ~sys_clk_i;
  host_bus_model host_bus_model_inst (.sys_clk_i(sys_clk_i),
    .io_addr_o(io_addr_i), .io_rd_o(io_rd_i), .io_wr_o(io_wr_i),
    .io_wdata_o(io_wdata_i), .io_rdata_i(io_rdata_o),
    .io_rvalid_i(io_rvalid_o));
  isolated_input_port_irq isolated_input_port_irq_inst (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .io_addr_i(io_addr_i),
    .io_rd_i(io_rd_i), .io_wr_i(io_wr_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o),
    .base_address_switch_i(base), .first_irq_line_sel_i(fsel),
    .second_irq_line_sel_i(ssel), .first_edge_select_i(fe),
    .second_edge_select_i(se), .isolated_input_i(inputs),
    .irq_line_o(irq_line_o));
  // ------------------------------------------------------------
  // checking helpers
  // ------------------------------------------------------------
  task automatic conclude();
    if (num_errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ------------------------------------------------------------
  // rules model: pin levels, latched flags, queued read answers
  // ------------------------------------------------------------
  // request lines due from the model flags and the routing straps
  function automatic logic [7:0] exp_lines();
    exp_lines = ((mdl_flag[0] != 0) ? fsel : 8'h00) |
                ((mdl_flag[1] != 0) ? ssel : 8'h00);
  endfunction
  // drive an irq channel pin; the model latches on the chosen edge
  task automatic set_irq(input int idx, input logic lvl);
    int   ch;
    logic edg;
    ch = (idx != 0) ? SECOND_CH : FIRST_CH;
    edg = (idx != 0) ? se : fe;
    if (inputs[ch] !== lvl && lvl == edg) mdl_flag[idx] = 1;
    inputs[ch] = lvl;
    mdl_in = inputs;
  endtask
  // write through the host; a hit on byte 0 or 2 clears a model flag
  task automatic host_wr(input logic [9:0] a);
    host_bus_model_inst.wr(a);
    if (a[9:2] == base && a[1:0] == OFS_BYTE0) mdl_flag[0] = 0;
    if (a[9:2] == base && a[1:0] == OFS_BYTE2) mdl_flag[1] = 0;
  endtask
  // read through the host; the answer due is queued before the strobe
  task automatic host_rd(input logic [9:0] a);
    int b;
    b = (mdl_in >> (8 * a[1:0])) & 32'h0000_00FF;
    exp_q.push_back((a[9:2] == base) ? (32'h0000_0100 | b) : 0);
    host_bus_model_inst.rd(a, v, d);
    chk({v, d}, 9'(exp_q.pop_front()));
  endtask
  // bounded wait for the request lines to match the model
  task automatic wait_irq();
    for (n = 0; n < 8 && irq_line_o !== exp_lines(); n++)
      @(posedge sys_clk_i) #1;
    chk({1'b0, irq_line_o}, {1'b0, exp_lines()});
    if (irq_line_o !== exp_lines()) conclude();
  endtask
  task automatic settle();
    repeat (6) @(posedge sys_clk_i) #1;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(11));
    inputs = 32'h0001_0000;
    mdl_in = inputs;
    mdl_flag = '{0, 0};
    base = 8'hC0 ^ (8'($urandom()) & 8'h3C);
    fsel = 8'h01;
    ssel = 8'h80;
    fe = EDGE_RISE;
    se = EDGE_FALL;
    repeat (3) @(posedge sys_clk_i) #1;
    nrst_i = 1'b1;
    settle();
    // live byte reads; irq channels held without events
    for (i = 0; i < 8; i++) begin
      inputs = ($urandom() & 32'hFFFE_FFFE) | 32'h0001_0000;
      mdl_in = inputs;
      settle();
      for (k = 0; k < 4; k++) host_rd({base, 2'(k)});
      host_rd({~base, OFS_BYTE0});
      wait_irq();
    end
    // every request line, default edges, set and clear
    for (i = 0; i < NUM_LINES; i++) begin
      fsel = 8'h01 << i;
      ssel = 8'h80 >> i;
      set_irq(0, 1'b1);
      wait_irq();
      host_wr({base, OFS_BYTE1});
      host_wr({base, OFS_BYTE3});
      host_wr({~base, OFS_BYTE0});
      wait_irq();
      host_wr({base, OFS_BYTE0});
      wait_irq();
      set_irq(0, 1'b0);
      set_irq(1, 1'b0);
      wait_irq();
      host_wr({base, OFS_BYTE2});
      wait_irq();
      set_irq(1, 1'b1);
      settle();
    end
    // swapped edges, second source disabled
    fe = EDGE_FALL;
    se = EDGE_RISE;
    ssel = NO_LINE;
    set_irq(1, 1'b0);
    set_irq(0, 1'b1);
    settle();
    set_irq(1, 1'b1);
    settle();
    wait_irq();
    set_irq(0, 1'b0);
    wait_irq();
    // both sources unrouted: lines drop while the flags hold
    fsel = NO_LINE;
    wait_irq();
    fsel = 8'h01;
    wait_irq();
    // reset in mid-run with channel 0 high: no false rise after it
    fe = EDGE_RISE;
    @(posedge sys_clk_i) #1 nrst_i = 1'b0;
    inputs[FIRST_CH] = 1'b1;
    mdl_in = inputs;
    mdl_flag = '{0, 0};
    repeat (2) @(posedge sys_clk_i) #1;
    nrst_i = 1'b1;
    settle();
    wait_irq();
    host_rd({base, OFS_BYTE0});
    conclude();
  end
endmodule // tb_top
